// File: boot_loader_pkg.sv
// boot loader package: clock ratios, image format constants, pin claims, states, crc step
// assumes a single core clock and an external serial flash holding the boot image
package boot_loader_pkg;

  // serial clock ratios, derived from the reference core rate and the link rates
  localparam int unsigned CORE_REF_HZ    = 400_000_000;
  localparam int unsigned QUAD_SCLK_HZ   = 50_000_000;
  localparam int unsigned SINGLE_SCLK_HZ = 2_500_000;
  localparam int unsigned QUAD_DIV       = CORE_REF_HZ / QUAD_SCLK_HZ;
  localparam int unsigned SINGLE_DIV     = CORE_REF_HZ / SINGLE_SCLK_HZ;
  localparam int          HALF_W         = 7;
  localparam logic [HALF_W-1:0] QUAD_HALF   = HALF_W'(QUAD_DIV / 2);
  localparam logic [HALF_W-1:0] SINGLE_HALF = HALF_W'(SINGLE_DIV / 2);

  // flash command phase
  localparam logic [7:0]  READ_CMD        = 8'h03;
  localparam logic [7:0]  QUAD_READ_CMD   = 8'h6b;
  localparam logic [23:0] START_ADDR      = 24'h000000;
  localparam logic [5:0]  CMD_LAST_BIT    = 6'h1f;
  localparam logic [5:0]  QUAD_DUMMY_LAST = 6'h07;

  // image checking
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_SKIP = 32'h0d15ab1e;

  // on-chip program ram
  localparam int          RAM_AW    = 18;
  localparam logic [31:0] RAM_BYTES = 32'h00040000;
  localparam logic [RAM_AW-1:0] LOAD_ADDR = 18'h00000;

  // pins the loader takes over
  typedef struct packed {
    logic       sel;
    logic       sclk;
    logic       spi_in;
    logic       spi_out;
    logic [3:0] qd;
  } pin_claim_t;

  localparam pin_claim_t NO_PINS     = '{sel: 1'b0, sclk: 1'b0, spi_in: 1'b0, spi_out: 1'b0,
                                         qd: 4'h0};
  localparam pin_claim_t QUAD_PINS   = '{sel: 1'b1, sclk: 1'b1, spi_in: 1'b0, spi_out: 1'b0,
                                         qd: 4'hf};
  localparam pin_claim_t SINGLE_PINS = '{sel: 1'b1, sclk: 1'b1, spi_in: 1'b1, spi_out: 1'b1,
                                         qd: 4'h0};

  // loader progress seen by the tile
  typedef struct packed {
    logic busy;
    logic error;
    logic started;
  } boot_status_t;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_CMD    = 9'h002,
    ST_DUMMY  = 9'h004,
    ST_SIZE   = 9'h008,
    ST_PROG   = 9'h010,
    ST_CHECK  = 9'h020,
    ST_VERIFY = 9'h040,
    ST_RUN    = 9'h080,
    ST_FAIL   = 9'h100
  } boot_state_t;

  // reflected crc-32, one byte, lsb first
  function automatic logic [31:0] crc32_byte(input logic [31:0] crc, input logic [7:0] data);
    logic [31:0] c;
    c = crc ^ {24'h000000, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// File: boot_ram.sv
// byte-wide program ram with one write port and one registered read port
// assumes writer and reader share the core clock
`timescale 1ns/1ps
module boot_ram
  import boot_loader_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              ce_i,
  input  wire logic              we_i,
  input  wire logic [RAM_AW-1:0] waddr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic [RAM_AW-1:0] raddr_i,
  output logic      [7:0]        rdata_o
);

  logic [7:0] mem [0:(1<<RAM_AW)-1];

  // write and registered read
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end

endmodule // boot_ram

// File: serial_clock_gen.sv
// serial clock divider, mode 0: idles low, pulses mark each rising and falling edge
// assumes half_i is held steady while run_i is high
`timescale 1ns/1ps
module serial_clock_gen
  import boot_loader_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              run_i,
  input  wire logic [HALF_W-1:0] half_i,
  output logic                   sclk_o,
  output logic                   rise_o,
  output logic                   fall_o
);

  logic [HALF_W-1:0] cnt;
  logic [HALF_W-1:0] next_cnt;
  logic              next_sclk;
  logic              next_rise;
  logic              next_fall;

  // count half periods; a high phase always finishes so the clock parks low
  always_comb begin
    next_cnt  = cnt;
    next_sclk = sclk_o;
    next_rise = 1'b0;
    next_fall = 1'b0;
    if (run_i || sclk_o) begin
      if (cnt == half_i - 1'b1) begin
        next_cnt  = '0;
        next_sclk = ~sclk_o;
        next_rise = ~sclk_o;
        next_fall = sclk_o;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end else begin
      next_cnt = '0;
    end
  end

  // divider state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt    <= '0;
      sclk_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else if (ce_i) begin
      cnt    <= next_cnt;
      sclk_o <= next_sclk;
      rise_o <= next_rise;
      fall_o <= next_fall;
    end
  end

endmodule // serial_clock_gen

// File: serial_flash_boot_loader.sv
// serial flash boot loader: reads the boot image from flash, fills ram, checks crc, starts
// assumes a strap pin picks quad or single-bit mode and flash pins are outside this clock
//
// Behaviour
// - quad mode claims exactly six pins: select, four data lines and serial clock.
// - single-bit mode claims exactly four pins: data in, select, serial clock, data out.
// - quad mode runs the serial clock at one eighth of the core clock.
// - single-bit mode runs the serial clock at the core clock divided by 160.
// - both modes start with a read command and the three-byte address zero.
// - the serial clock idles low and data is sampled on its rising edge.
// - quad mode takes each byte as two nibbles, low nibble first.
// - single-bit mode takes each byte least-significant bit first.
// - size and check words are assembled little-endian.
// - the program fills ram from the lowest address and runs from that address.
// - a check word equal to the skip value bypasses the crc comparison.
// - the crc covers the size bytes and then every program byte in order.
// - the crc is reflected 0xedb88320, preset to all ones, residue inverted.
// - the pin assignment is fixed and cannot be changed.
`timescale 1ns/1ps
module serial_flash_boot_loader
  import boot_loader_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              boot_quad_i,
  input  wire logic              spi_in_i,
  input  wire logic [3:0]        quad_data_lines_i,
  output logic                   sel_n_o,
  output logic                   sclk_o,
  output logic                   spi_out_o,
  output logic      [3:0]        quad_data_lines_o,
  output logic      [3:0]        quad_data_lines_oe_o,
  output pin_claim_t             pins_claimed_o,
  output boot_status_t           status_o,
  output logic                   exec_start_o,
  output logic      [RAM_AW-1:0] exec_addr_o,
  input  wire logic [RAM_AW-1:0] ram_rd_addr_i,
  output logic      [7:0]        ram_rd_data_o
);

  // pin synchronisers: first stage feeds only the second; not reset, so the strap has
  // settled by the time reset ends
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic       strap_quad;
  logic       din_single;
  logic [3:0] din_quad;

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      pin_s1 <= {boot_quad_i, spi_in_i, quad_data_lines_i};
      pin_s2 <= pin_s1;
    end
  end

  assign strap_quad = pin_s2[5];
  assign din_single = pin_s2[4];
  assign din_quad   = pin_s2[3:0];

  // loader state
  boot_state_t       state;
  logic              quad;
  logic [31:0]       shift_out;
  logic [5:0]        bit_cnt;
  logic [7:0]        byte_sr;
  logic [2:0]        unit_cnt;
  logic [1:0]        byte_idx;
  logic [31:0]       size;
  logic [31:0]       load_cnt;
  logic [31:0]       check;
  logic [31:0]       crc;
  logic              ram_we;
  logic [RAM_AW-1:0] ram_waddr;
  logic [7:0]        ram_wdata;

  boot_state_t       next_state;
  logic              next_quad;
  logic [31:0]       next_shift_out;
  logic [5:0]        next_bit_cnt;
  logic [7:0]        next_byte_sr;
  logic [2:0]        next_unit_cnt;
  logic [1:0]        next_byte_idx;
  logic [31:0]       next_size;
  logic [31:0]       next_load_cnt;
  logic [31:0]       next_check;
  logic [31:0]       next_crc;
  logic              next_ram_we;
  logic [RAM_AW-1:0] next_ram_waddr;
  logic [7:0]        next_ram_wdata;
  logic              next_sel_n;
  logic              next_spi_out;
  logic [3:0]        next_qd_o;
  logic [3:0]        next_qd_oe;
  pin_claim_t        next_claim;
  boot_status_t      next_status;
  logic              next_exec_start;
  logic [RAM_AW-1:0] next_exec_addr;

  // serial clock
  logic              sclk_run;
  logic              sclk_rise;
  logic              sclk_fall;
  logic [HALF_W-1:0] half;

  assign half     = quad ? QUAD_HALF : SINGLE_HALF;
  assign sclk_run = (state == ST_CMD) || (state == ST_DUMMY) || (state == ST_SIZE) ||
                    (state == ST_PROG) || (state == ST_CHECK);

  serial_clock_gen u_clk (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .run_i  (sclk_run),
    .half_i (half),
    .sclk_o (sclk_o),
    .rise_o (sclk_rise),
    .fall_o (sclk_fall)
  );

  boot_ram u_ram (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (ram_we),
    .waddr_i (ram_waddr),
    .wdata_i (ram_wdata),
    .raddr_i (ram_rd_addr_i),
    .rdata_o (ram_rd_data_o)
  );

  // byte assembly from the sampled data lines
  logic       receiving;
  logic       byte_done;
  logic [7:0] byte_val;
  logic [2:0] unit_last;

  assign receiving = (state == ST_SIZE) || (state == ST_PROG) || (state == ST_CHECK);
  assign unit_last = quad ? 3'h1 : 3'h7;

  always_comb begin
    byte_val = byte_sr;
    if (quad) begin
      byte_val = {din_quad, byte_sr[7:4]};
    end else begin
      byte_val = {din_single, byte_sr[7:1]};
    end
    byte_done = receiving && sclk_rise && (unit_cnt == unit_last);
  end

  // next state and outputs
  always_comb begin
    next_state      = state;
    next_quad       = quad;
    next_shift_out  = shift_out;
    next_bit_cnt    = bit_cnt;
    next_byte_sr    = byte_sr;
    next_unit_cnt   = unit_cnt;
    next_byte_idx   = byte_idx;
    next_size       = size;
    next_load_cnt   = load_cnt;
    next_check      = check;
    next_crc        = crc;
    next_ram_we     = 1'b0;
    next_ram_waddr  = ram_waddr;
    next_ram_wdata  = ram_wdata;
    next_sel_n      = sel_n_o;
    next_spi_out    = spi_out_o;
    next_qd_o       = quad_data_lines_o;
    next_qd_oe      = quad_data_lines_oe_o;
    next_claim      = pins_claimed_o;
    next_status     = status_o;
    next_exec_start = 1'b0;
    next_exec_addr  = exec_addr_o;

    if (receiving && sclk_rise) begin
      next_byte_sr  = byte_val;
      next_unit_cnt = byte_done ? 3'h0 : unit_cnt + 3'h1;
    end

    unique case (state)
      ST_IDLE: begin
        next_quad      = strap_quad;
        next_status    = '{busy: 1'b1, error: 1'b0, started: 1'b0};
        next_crc       = CRC_INIT;
        next_bit_cnt   = 6'h00;
        next_unit_cnt  = 3'h0;
        next_byte_idx  = 2'h0;
        next_load_cnt  = 32'h0;
        next_shift_out = {(strap_quad ? QUAD_READ_CMD : READ_CMD), START_ADDR};
        next_spi_out   = READ_CMD[7];
        next_qd_o      = {3'h0, QUAD_READ_CMD[7]};
        next_qd_oe     = strap_quad ? 4'h1 : 4'h0;
        next_claim     = strap_quad ? QUAD_PINS : SINGLE_PINS;
        next_sel_n     = 1'b0;
        next_state     = ST_CMD;
      end
      ST_CMD: begin
        if (sclk_rise) begin
          next_bit_cnt = bit_cnt + 6'h01;
          if (bit_cnt == CMD_LAST_BIT) begin
            next_bit_cnt = 6'h00;
            next_qd_oe   = 4'h0;
            next_state   = quad ? ST_DUMMY : ST_SIZE;
          end
        end else if (sclk_fall) begin
          // shift the next command bit out on the falling edge
          next_shift_out = {shift_out[30:0], 1'b0};
          next_spi_out   = shift_out[30];
          next_qd_o      = {3'h0, shift_out[30]};
        end
      end
      ST_DUMMY: begin
        if (sclk_rise) begin
          next_bit_cnt = bit_cnt + 6'h01;
          if (bit_cnt == QUAD_DUMMY_LAST) begin
            next_state = ST_SIZE;
          end
        end
      end
      ST_SIZE: begin
        if (byte_done) begin
          next_size     = {byte_val, size[31:8]};
          next_crc      = crc32_byte(crc, byte_val);
          next_byte_idx = byte_idx + 2'h1;
          if (byte_idx == 2'h3) begin
            if (next_size == 32'h0) begin
              next_state = ST_CHECK;
            end else if (next_size > RAM_BYTES) begin
              next_status = '{busy: 1'b0, error: 1'b1, started: 1'b0};
              next_state  = ST_FAIL;
            end else begin
              next_state = ST_PROG;
            end
          end
        end
      end
      ST_PROG: begin
        if (byte_done) begin
          next_ram_we    = 1'b1;
          next_ram_waddr = LOAD_ADDR + load_cnt[RAM_AW-1:0];
          next_ram_wdata = byte_val;
          next_crc       = crc32_byte(crc, byte_val);
          next_load_cnt  = load_cnt + 32'h1;
          if (load_cnt == size - 32'h1) begin
            next_state = ST_CHECK;
          end
        end
      end
      ST_CHECK: begin
        if (byte_done) begin
          next_check    = {byte_val, check[31:8]};
          next_byte_idx = byte_idx + 2'h1;
          if (byte_idx == 2'h3) begin
            next_state = ST_VERIFY;
          end
        end
      end
      ST_VERIFY: begin
        // wait for the clock to park low before releasing select
        if (!sclk_o) begin
          next_sel_n = 1'b1;
          next_claim = NO_PINS;
          if ((check == CRC_SKIP) || (check == ~crc)) begin
            next_exec_start = 1'b1;
            next_exec_addr  = LOAD_ADDR;
            next_status     = '{busy: 1'b0, error: 1'b0, started: 1'b1};
            next_state      = ST_RUN;
          end else begin
            next_status = '{busy: 1'b0, error: 1'b1, started: 1'b0};
            next_state  = ST_FAIL;
          end
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      ST_FAIL: begin
        // an early stop lets the clock park low before select goes up
        if (!sclk_o) begin
          next_sel_n = 1'b1;
          next_claim = NO_PINS;
        end
      end
      default: begin
        next_sel_n  = 1'b1;
        next_claim  = NO_PINS;
        next_qd_oe  = 4'h0;
        next_status = '{busy: 1'b0, error: 1'b1, started: 1'b0};
        next_state  = ST_FAIL;
      end
    endcase
  end

  // loader registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state                <= ST_IDLE;
      quad                 <= 1'b0;
      shift_out            <= 32'h0;
      bit_cnt              <= 6'h00;
      byte_sr              <= 8'h00;
      unit_cnt             <= 3'h0;
      byte_idx             <= 2'h0;
      size                 <= 32'h0;
      load_cnt             <= 32'h0;
      check                <= 32'h0;
      crc                  <= CRC_INIT;
      ram_we               <= 1'b0;
      ram_waddr            <= LOAD_ADDR;
      ram_wdata            <= 8'h00;
      sel_n_o              <= 1'b1;
      spi_out_o            <= 1'b0;
      quad_data_lines_o    <= 4'h0;
      quad_data_lines_oe_o <= 4'h0;
      pins_claimed_o       <= NO_PINS;
      status_o             <= '{busy: 1'b0, error: 1'b0, started: 1'b0};
      exec_start_o         <= 1'b0;
      exec_addr_o          <= LOAD_ADDR;
    end else if (ce_i) begin
      state                <= next_state;
      quad                 <= next_quad;
      shift_out            <= next_shift_out;
      bit_cnt              <= next_bit_cnt;
      byte_sr              <= next_byte_sr;
      unit_cnt             <= next_unit_cnt;
      byte_idx             <= next_byte_idx;
      size                 <= next_size;
      load_cnt             <= next_load_cnt;
      check                <= next_check;
      crc                  <= next_crc;
      ram_we               <= next_ram_we;
      ram_waddr            <= next_ram_waddr;
      ram_wdata            <= next_ram_wdata;
      sel_n_o              <= next_sel_n;
      spi_out_o            <= next_spi_out;
      quad_data_lines_o    <= next_qd_o;
      quad_data_lines_oe_o <= next_qd_oe;
      pins_claimed_o       <= next_claim;
      status_o             <= next_status;
      exec_start_o         <= next_exec_start;
      exec_addr_o          <= next_exec_addr;
    end
  end

endmodule // serial_flash_boot_loader

// File: boot_loader_props.sv
// checker: serial clock timing, pin claims and start or error outcome of the boot loader
// assumes the strap stays steady while the loader runs and ce_i is held high
`timescale 1ns/1ps
module boot_loader_props
  import boot_loader_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              boot_quad_i,
  input wire logic              sel_n_o,
  input wire logic              sclk_o,
  input wire logic              spi_out_o,
  input wire logic [3:0]        quad_data_lines_o,
  input wire logic [3:0]        quad_data_lines_oe_o,
  input wire pin_claim_t        pins_claimed_o,
  input wire boot_status_t      status_o,
  input wire logic              exec_start_o,
  input wire logic [RAM_AW-1:0] exec_addr_o
);
  localparam int QH = 3;   // quad half period less one
  localparam int SH = 79;  // single-bit half period less one

  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic       prev_sclk;
  logic       live;
  logic       next_live;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // cycles since the serial clock last moved, live after its first move in a frame
  always_comb begin
    next_cnt  = (sel_n_o || sclk_o != prev_sclk) ? 7'h00 : cnt + 7'h01;
    next_live = !sel_n_o && (live || sclk_o != prev_sclk);
  end

  // register the helper state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt       <= 7'h00;
      prev_sclk <= 1'b0;
      live      <= 1'b0;
    end else begin
      cnt       <= next_cnt;
      prev_sclk <= sclk_o;
      live      <= next_live;
    end
  end

  // start pulse: right address and status, then gone
  sequence s_start;
    exec_addr_o == '0 && status_o.started && !status_o.error ##1 !exec_start_o;
  endsequence

  a_sclk_half_rate: assert property (
    live && !sel_n_o && sclk_o != prev_sclk |-> cnt == (pins_claimed_o.qd[0] ? QH : SH))
    else $error("serial clock half period wrong");
  a_sclk_idle_low: assert property (
    sel_n_o [*3] |-> !sclk_o)
    else $error("serial clock not low while idle");
  a_data_stable_rise: assert property (
    $rose(sclk_o) |-> $stable(spi_out_o) && $stable(quad_data_lines_o))
    else $error("data out moved at sampling edge");
  a_quad_pins_six: assert property (
    !sel_n_o && boot_quad_i |-> pins_claimed_o == 8'hcf)
    else $error("quad pin claim wrong");
  a_single_pins_four: assert property (
    !sel_n_o && !boot_quad_i |-> pins_claimed_o == 8'hf0)
    else $error("single-bit pin claim wrong");
  a_idle_pins_none: assert property (
    sel_n_o [*2] |-> pins_claimed_o == 8'h00 && quad_data_lines_oe_o == 4'h0)
    else $error("pins held while idle");
  a_quad_cmd_oe: assert property (
    quad_data_lines_oe_o != 4'h0 |-> boot_quad_i && !sel_n_o && quad_data_lines_oe_o == 4'h1)
    else $error("data line driven out of quad command");
  a_start_pulse: assert property (
    exec_start_o |-> sel_n_o ##0 s_start)
    else $error("start pulse malformed");
  a_error_no_start: assert property (
    status_o.error |-> !status_o.started && !exec_start_o)
    else $error("start despite error");
  a_sclk_selected: assert property (
    $rose(sclk_o) |-> !sel_n_o && $past(!sel_n_o))
    else $error("serial clock outside select");
endmodule // boot_loader_props

// File: flash_model.sv
// flash model: answers a read from address zero with the stored image, mode 0
// assumes the loader drives select and serial clock; tb fills mem and reads cmd and rises
`timescale 1ns/1ps
module flash_model (
  input  wire logic       quad_i,
  input  wire logic       sel_n_i,
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  output logic      [3:0] qd_o
);
  logic [7:0]  mem [0:255];
  logic [31:0] cmd;
  int          rises;
  int          pos;

  // outputs defined from time zero
  initial begin
    miso_o = 1'b0;
    qd_o   = 4'h0;
    rises  = 0;
    cmd    = '0;
  end

  // new frame on select
  always @(negedge sel_n_i) begin
    rises = 0;
    cmd   = '0;
  end

  always @(posedge sclk_i) begin
    if (!sel_n_i) begin
      if (rises < 32) cmd = {cmd[30:0], mosi_i};
      rises++;
    end
  end

  // image driven after falling edge, low nibble or lsb first
  always @(negedge sclk_i) begin
    pos = rises - (quad_i ? 40 : 32);
    if (!sel_n_i && pos >= 0 && pos < 512) begin
      if (quad_i) qd_o = pos[0] ? mem[pos/2][7:4] : mem[pos/2][3:0];
      else miso_o = mem[pos/8][pos%8];
    end
  end

  // released lines show the inverse of the last value
  always @(posedge sel_n_i) begin
    miso_o = ~miso_o;
    qd_o   = ~qd_o;
  end
endmodule // flash_model

// File: tb.sv
// testbench: boots the loader from the flash model in both modes and judges the outcome
// assumes ce_i held high and the strap changed only during reset
`timescale 1ns/1ps
module tb;
  import boot_loader_pkg::*;

  logic              clk_i         = 1'b0;
  logic              rst_i         = 1'b1;
  logic              boot_quad_i   = 1'b0;
  logic [RAM_AW-1:0] ram_rd_addr_i = '0;
  logic              spi_in_i;
  logic [3:0]        quad_data_lines_i;
  logic [3:0]        qd;
  logic              sel_n_o;
  logic              sclk_o;
  logic              spi_out_o;
  logic [3:0]        quad_data_lines_o;
  logic [3:0]        quad_data_lines_oe_o;
  pin_claim_t        pins_claimed_o;
  boot_status_t      status_o;
  logic              exec_start_o;
  logic [RAM_AW-1:0] exec_addr_o;
  logic [7:0]        ram_rd_data_o;
  int                n_mismatch    = 0;
  int                n_tests       = 0;

  // 20 MHz core clock
  always #25 clk_i = ~clk_i;

  // data line level from both drivers
  assign quad_data_lines_i = (quad_data_lines_oe_o & quad_data_lines_o) |
                             (~quad_data_lines_oe_o & qd);

  serial_flash_boot_loader serial_flash_boot_loader_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .boot_quad_i(boot_quad_i),
    .spi_in_i(spi_in_i), .quad_data_lines_i(quad_data_lines_i), .sel_n_o(sel_n_o),
    .sclk_o(sclk_o), .spi_out_o(spi_out_o), .quad_data_lines_o(quad_data_lines_o),
    .quad_data_lines_oe_o(quad_data_lines_oe_o), .pins_claimed_o(pins_claimed_o),
    .status_o(status_o), .exec_start_o(exec_start_o), .exec_addr_o(exec_addr_o),
    .ram_rd_addr_i(ram_rd_addr_i), .ram_rd_data_o(ram_rd_data_o));

  flash_model flash_model_i (
    .quad_i(boot_quad_i), .sel_n_i(sel_n_o), .sclk_i(sclk_o),
    .mosi_i(boot_quad_i ? quad_data_lines_i[0] : spi_out_o), .miso_o(spi_in_i), .qd_o(qd));

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: %s is %h, expected %h", $time, what, seen, exp);
    end
  endtask

  // image: size, program, check word; mode 0 good, 1 corrupt, 2 skip value, 3 size beyond ram
  task automatic build(input int n, input int mode);
    logic [31:0] c;
    for (int i = 0; i < 4; i++) begin
      flash_model_i.mem[i] = 8'(n >> (8 * i));
    end
    for (int i = 0; i < n; i++) begin
      flash_model_i.mem[4 + i] = 8'h3c + 8'(i * 41);
    end
    c = 32'hffffffff;
    for (int i = 0; i < n + 4; i++) begin
      c = c ^ {24'h000000, flash_model_i.mem[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
      end
    end
    c = ~c;
    if (mode == 1) c = c ^ 32'h00000100;
    if (mode == 2) c = 32'h0d15ab1e;
    for (int i = 0; i < 4; i++) begin
      flash_model_i.mem[4 + n + i] = c[8 * i +: 8];
    end
    if (mode == 3) flash_model_i.mem[2] = 8'h05;
  endtask

  // one full boot from reset, then outcome, link counts and ram contents
  task automatic boot(input logic quad, input int n, input int mode);
    int t;
    int k;
    build(n, mode);
    @(posedge clk_i);
    boot_quad_i <= quad;
    rst_i       <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t = 0;
    while (exec_start_o !== 1'b1 && status_o.error !== 1'b1 && t < 30000) begin
      @(posedge clk_i);
      #1;
      t++;
      if (t == 50) begin
        check(32'(pins_claimed_o), quad ? 32'hcf : 32'hf0, "pins");
        check(32'(status_o.busy), 32'h1, "busy");
      end
    end
    check(32'(exec_start_o), 32'(mode % 2 == 0), "start");
    check(32'(status_o.error), 32'(mode % 2 == 1), "error");
    check(32'(status_o), (mode % 2 == 1) ? 32'h2 : 32'h1, "status");
    check(flash_model_i.cmd, quad ? 32'h6b000000 : 32'h03000000, "command");
    check(32'(exec_addr_o), 32'h0, "start address");
    repeat (90) @(posedge clk_i);
    #1;
    k = (mode == 3) ? 4 : n + 8;
    k = quad ? 40 + 2 * k : 32 + 8 * k;
    check(32'(flash_model_i.rises), 32'(k), "clocks");
    check(32'(sel_n_o), 32'h1, "select");
    check(32'(pins_claimed_o), 32'h0, "pins idle");
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      ram_rd_addr_i <= RAM_AW'(i);
      repeat (2) @(posedge clk_i);
      #1;
      check(32'(ram_rd_data_o), 32'(flash_model_i.mem[4 + i]), "ram byte");
    end
  endtask

  // single-bit mode, good image
  task automatic single_good();
    boot(1'b0, 4, 0);
  endtask

  // quad mode, good image
  task automatic quad_good();
    boot(1'b1, 6, 0);
  endtask

  // quad mode, corrupted check word
  task automatic quad_bad();
    boot(1'b1, 3, 1);
  endtask

  // quad mode, skip value in place of the check word
  task automatic quad_skip();
    boot(1'b1, 5, 2);
  endtask

  // quad mode, empty program
  task automatic quad_empty();
    boot(1'b1, 0, 0);
  endtask

  // quad mode, size field beyond ram: error right after the size bytes
  task automatic quad_big();
    boot(1'b1, 0, 3);
  endtask

  // counts and verdict
  task automatic results();
    $display("tests %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    single_good();
    quad_good();
    quad_bad();
    quad_skip();
    quad_empty();
    quad_big();
    results();
  end

  // watchdog against a hung boot
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    results();
  end
endmodule // tb

bind serial_flash_boot_loader boot_loader_props boot_loader_props_i (
  .clk_i(clk_i), .rst_i(rst_i), .boot_quad_i(boot_quad_i), .sel_n_o(sel_n_o),
  .sclk_o(sclk_o), .spi_out_o(spi_out_o), .quad_data_lines_o(quad_data_lines_o),
  .quad_data_lines_oe_o(quad_data_lines_oe_o), .pins_claimed_o(pins_claimed_o),
  .status_o(status_o), .exec_start_o(exec_start_o), .exec_addr_o(exec_addr_o));
